//--- prp_ext_model.sv
// external hardware on the port pins; released pins fall to their pull-down
`timescale 1ns/1ps
`default_nettype none
module prp_ext_model (
    input  wire logic        clock,
    input  wire logic [31:0] pin_out,
    input  wire logic [31:0] pin_oe,
    output logic      [31:0] pin_in,
    output logic      [4:0]  input_strobe
);
    logic [31:0] drv = 32'h0;
    logic [31:0] drv_en = 32'h0;
    logic [4:0]  strb = 5'h0;
    assign pin_in = (pin_oe & pin_out) | (~pin_oe & drv_en & drv);
    assign input_strobe = strb;
    task automatic send(input logic [31:0] w, input int wb, input int p);
        for (int i = 0; i < 32; i += wb) begin
            @(posedge clock);
            drv <= w >> i;
            drv_en <= (wb == 32) ? 32'hFFFF_FFFF : ((32'h1 << wb) - 32'h1);
            strb[p] <= 1'b1;
            @(posedge clock);
            drv <= ~(w >> i);
            strb[p] <= 1'b0;
        end
        @(posedge clock);
        drv_en <= 32'h0;
    endtask
    task automatic tick_src(input int n);
        for (int i = 0; i < n; i++) begin
            @(posedge clock);
            drv_en[0] <= 1'b1;
            drv[0] <= 1'b1;
            @(posedge clock);
            drv[0] <= 1'b0;
            @(posedge clock);
        end
        drv_en[0] <= 1'b0;
    endtask
endmodule
`default_nettype wire

//--- prp_pkg.sv
// types shared by the port and clock block logic
`default_nettype none
package prp_pkg;
    typedef struct packed {
        logic        en;
        logic        dir_out;
        logic        oc;
        logic        timed;
        logic        cond_en;
        logic        strb_en;
        logic [2:0]  clk_sel;
        logic [31:0] cond;
        logic [15:0] cnt;
        logic [15:0] time_at;
        logic [15:0] stamp;
        logic [31:0] xfer;
        logic [31:0] sreg;
        logic        xfer_full;
        logic        sreg_full;
        logic [5:0]  nbits;
        logic [31:0] out_val;
        logic        ostrobe;
        logic        evt;
    } prp_port_s;

    typedef struct packed {
        logic       src_port;
        logic [7:0] div;
        logic [7:0] divcnt;
        logic       prev_pin;
    } prp_cb_s;

    typedef struct packed {
        prp_port_s [4:0] port;
        prp_cb_s [5:0]   cb;
        logic [31:0]     prdata;
        logic            pslverr;
    } prp_state_s;
endpackage
`default_nettype wire

//--- prp_regs.svh
// register map, field positions, widths and reset values of the port block
`ifndef PRP_REGS_SVH
`define PRP_REGS_SVH

`define PRP_NPORT        5
`define PRP_NCB          6
`define PRP_NPIN         32
`define PRP_XFER_W       32
`define PRP_CNT_W        16
`define PRP_DIV_W        8
`define PRP_REF_MHZ      100

`define PRP_W0           1
`define PRP_W1           4
`define PRP_W2           8
`define PRP_W3           16
`define PRP_W4           32

// port registers: port base is the port index times PRP_PORT_STRIDE
`define PRP_PORT_STRIDE  12'h020
`define PRP_CB_BASE      12'h100
`define PRP_R_CTRL       3'h0
`define PRP_R_DATA       3'h1
`define PRP_R_TIME       3'h2
`define PRP_R_COUNT      3'h3
`define PRP_R_STAMP      3'h4
`define PRP_R_STATUS     3'h5
`define PRP_R_COND       3'h6

`define PRP_CTRL_EN      0
`define PRP_CTRL_OUT     1
`define PRP_CTRL_OC      2
`define PRP_CTRL_TIMED   3
`define PRP_CTRL_COND    4
`define PRP_CTRL_STRB    5
`define PRP_CTRL_CS_LO   8
`define PRP_CTRL_CS_HI   10
`define PRP_ST_XFULL     0
`define PRP_ST_SFULL     1
`define PRP_CB_SRC       0
`define PRP_CB_DIV_LO    8
`define PRP_CB_DIV_HI    15

`define PRP_CS_RESET     3'h0
`define PRP_LINK_MASK    32'hFF00_0000

`endif

//--- prp_top.sv
// port block with serialising ports, port counters and clock blocks, APB slave
`include "prp_regs.svh"
`timescale 1ns/1ps
`default_nettype none
module prp_top (
    input  wire logic        clock,
    input  wire logic        rst_b,
    input  wire logic        clk_en,
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [11:0] paddr,
    input  wire logic [31:0] pwdata,
    output logic      [31:0] prdata,
    output logic             pready,
    output logic             pslverr,
    input  wire logic [31:0] pin_in,
    output logic      [31:0] pin_out,
    output logic      [31:0] pin_oe,
    input  wire logic        link_enable,
    input  wire logic [4:0]  input_strobe,
    output logic      [4:0]  output_strobe,
    output logic      [4:0]  port_event
);
    localparam int unsigned PW [`PRP_NPORT] = '{`PRP_W0, `PRP_W1, `PRP_W2, `PRP_W3, `PRP_W4};
    // pins that an enabled link takes away from the ports
    localparam logic [`PRP_NPIN-1:0] LINK_MASK = `PRP_LINK_MASK;

    prp_pkg::prp_state_s st_reg;
    prp_pkg::prp_state_s st_next;
    logic [`PRP_NCB-1:0] cb_tick;
    logic [4:0]          owner_sel [`PRP_NPIN];

    // pin ownership: narrowest enabled port covering each pin
    always_comb begin
        for (int i = 0; i < `PRP_NPIN; i++) begin
            owner_sel[i] = '0;
            for (int p = `PRP_NPORT - 1; p >= 0; p--) begin
                // unshared pins stay with the wider port
                if (st_reg.port[p].en && (i < PW[p])) begin
                    owner_sel[i] = 5'(1 << p);
                end
            end
        end
    end

    always_comb begin
        for (int i = 0; i < `PRP_NPIN; i++) begin
            pin_out[i] = 1'b0;
            pin_oe[i]  = 1'b0;
            for (int p = 0; p < `PRP_NPORT; p++) begin
                // the owning port's direction applies to all its pins
                if (owner_sel[i][p] && st_reg.port[p].dir_out) begin
                    // open collector only sinks, a one floats
                    // chosen by the owning port's own bit
                    if (st_reg.port[p].oc) begin
                        pin_out[i] = 1'b0;
                        pin_oe[i]  = ~st_reg.port[p].out_val[i];
                    end else begin
                        pin_out[i] = st_reg.port[p].out_val[i];
                        pin_oe[i]  = 1'b1;
                    end
                end
            end
            // an enabled link takes its pins from every port
            if (link_enable && LINK_MASK[i]) begin
                pin_oe[i]  = 1'b0;
                pin_out[i] = 1'b0;
            end
        end
    end

    // clock block ticks, block zero is the reference and ticks every cycle
    always_comb begin
        for (int c = 0; c < `PRP_NCB; c++) begin
            if (c == 0) begin
                cb_tick[c] = 1'b1;
            end else if (st_reg.cb[c].src_port) begin
                // rising edge of the one-bit port pin
                cb_tick[c] = pin_in[0] && !st_reg.cb[c].prev_pin
                             && (st_reg.cb[c].divcnt == st_reg.cb[c].div);
            end else begin
                cb_tick[c] = (st_reg.cb[c].divcnt == st_reg.cb[c].div);
            end
        end
    end

    always_comb begin
        logic [31:0] pv;
        logic [31:0] shifted;
        logic        go;
        logic [2:0]  ri;
        logic [2:0]  pi;
        logic [2:0]  ci;
        logic        wr;
        logic        rd_setup;
        logic        addr_ok;
        pv       = '0;
        shifted  = '0;
        go       = 1'b0;
        ri       = paddr[4:2];
        pi       = paddr[7:5];
        ci       = paddr[4:2];
        wr       = psel && penable && pwrite;
        rd_setup = psel && !penable;
        // only aligned words inside the low window decode, the rest is unmapped
        addr_ok  = (paddr[1:0] == 2'h0) && (paddr[11:9] == 3'h0);
        st_next  = st_reg;

        for (int c = 1; c < `PRP_NCB; c++) begin
            st_next.cb[c].prev_pin = pin_in[0];
            if (!st_reg.cb[c].src_port || (pin_in[0] && !st_reg.cb[c].prev_pin)) begin
                if (st_reg.cb[c].divcnt == st_reg.cb[c].div) begin
                    st_next.cb[c].divcnt = '0;
                end else begin
                    st_next.cb[c].divcnt = st_reg.cb[c].divcnt + 8'h01;
                end
            end
        end

        // reading input data frees the transfer register; a capture in the
        // same cycle is applied after this and wins
        if (psel && penable && !pwrite && addr_ok && !paddr[8] && (pi < 3'(`PRP_NPORT))
            && (ri == `PRP_R_DATA) && !st_reg.port[pi].dir_out) begin
            st_next.port[pi].xfer_full = 1'b0;
        end

        for (int p = 0; p < `PRP_NPORT; p++) begin
            st_next.port[p].evt     = 1'b0;
            st_next.port[p].ostrobe = 1'b0;
            pv = pin_in & 32'((64'h1 << PW[p]) - 64'h1);
            if (st_reg.port[p].en && cb_tick[st_reg.port[p].clk_sel]) begin
                // one step per block tick, wraps at the top
                st_next.port[p].cnt = st_reg.port[p].cnt + 16'h0001;
                go = !st_reg.port[p].timed || (st_reg.port[p].cnt == st_reg.port[p].time_at);
                if (st_reg.port[p].dir_out) begin
                    if (st_reg.port[p].sreg_full) begin
                        // shift by the full nominal width
                        st_next.port[p].out_val = st_reg.port[p].sreg;
                        st_next.port[p].sreg    = st_reg.port[p].sreg >> PW[p];
                        st_next.port[p].nbits   = st_reg.port[p].nbits + 6'(PW[p]);
                        st_next.port[p].ostrobe = st_reg.port[p].strb_en;
                        if (32'(st_reg.port[p].nbits) + PW[p] >= `PRP_XFER_W) begin
                            st_next.port[p].sreg_full = 1'b0;
                        end
                    end else if (st_reg.port[p].xfer_full && go) begin
                        st_next.port[p].sreg      = st_reg.port[p].xfer;
                        st_next.port[p].sreg_full = 1'b1;
                        st_next.port[p].xfer_full = 1'b0;
                        st_next.port[p].nbits     = '0;
                        st_next.port[p].timed     = 1'b0;
                        st_next.port[p].stamp     = st_reg.port[p].cnt;
                        st_next.port[p].evt       = 1'b1;
                    end
                end else begin
                    if (st_reg.port[p].cond_en && (pv != st_reg.port[p].cond)) begin
                        go = 1'b0;
                    end
                    // sample only with the input strobe
                    if (st_reg.port[p].strb_en && !input_strobe[p]) begin
                        go = 1'b0;
                    end
                    if (go) begin
                        // deserialise into the top of the shift register
                        shifted = (PW[p] == `PRP_XFER_W) ? pv :
                                  ((st_reg.port[p].sreg >> PW[p])
                                   | 32'(pv << (`PRP_XFER_W - PW[p])));
                        st_next.port[p].sreg  = shifted;
                        st_next.port[p].nbits = st_reg.port[p].nbits + 6'(PW[p]);
                        if (32'(st_reg.port[p].nbits) + PW[p] >= `PRP_XFER_W) begin
                            st_next.port[p].nbits     = '0;
                            st_next.port[p].xfer      = shifted;
                            st_next.port[p].xfer_full = 1'b1;
                            st_next.port[p].timed     = 1'b0;
                            st_next.port[p].stamp     = st_reg.port[p].cnt;
                            st_next.port[p].evt       = 1'b1;
                        end
                    end
                end
            end
        end

        // zero-wait slave while clk_en is high, read data prepared in the setup cycle
        if (rd_setup) begin
            st_next.prdata  = '0;
            st_next.pslverr = 1'b0;
            if (addr_ok && !paddr[8] && (pi < 3'(`PRP_NPORT))) begin
                unique case (ri)
                    `PRP_R_CTRL: begin
                        st_next.prdata[`PRP_CTRL_EN]    = st_reg.port[pi].en;
                        st_next.prdata[`PRP_CTRL_OUT]   = st_reg.port[pi].dir_out;
                        st_next.prdata[`PRP_CTRL_OC]    = st_reg.port[pi].oc;
                        st_next.prdata[`PRP_CTRL_TIMED] = st_reg.port[pi].timed;
                        st_next.prdata[`PRP_CTRL_COND]  = st_reg.port[pi].cond_en;
                        st_next.prdata[`PRP_CTRL_STRB]  = st_reg.port[pi].strb_en;
                        st_next.prdata[`PRP_CTRL_CS_HI:`PRP_CTRL_CS_LO] = st_reg.port[pi].clk_sel;
                    end
                    `PRP_R_DATA:   st_next.prdata = st_reg.port[pi].xfer;
                    `PRP_R_TIME:   st_next.prdata[15:0] = st_reg.port[pi].time_at;
                    `PRP_R_COUNT:  st_next.prdata[15:0] = st_reg.port[pi].cnt;
                    `PRP_R_STAMP:  st_next.prdata[15:0] = st_reg.port[pi].stamp;
                    `PRP_R_STATUS: begin
                        st_next.prdata[`PRP_ST_XFULL] = st_reg.port[pi].xfer_full;
                        st_next.prdata[`PRP_ST_SFULL] = st_reg.port[pi].sreg_full;
                    end
                    `PRP_R_COND:   st_next.prdata = st_reg.port[pi].cond;
                    default:       st_next.pslverr = 1'b1;
                endcase
            end else if (addr_ok && paddr[8] && (paddr[7:5] == 3'h0)
                         && (ci < 3'(`PRP_NCB))) begin
                st_next.prdata[`PRP_CB_SRC] = st_reg.cb[ci].src_port;
                st_next.prdata[`PRP_CB_DIV_HI:`PRP_CB_DIV_LO] = st_reg.cb[ci].div;
            end else begin
                st_next.pslverr = 1'b1;
            end
        end

        if (wr && !st_reg.pslverr && !paddr[8] && (pi < 3'(`PRP_NPORT))) begin
            unique case (ri)
                `PRP_R_CTRL: begin
                    st_next.port[pi].en      = pwdata[`PRP_CTRL_EN];
                    st_next.port[pi].dir_out = pwdata[`PRP_CTRL_OUT];
                    st_next.port[pi].oc      = pwdata[`PRP_CTRL_OC];
                    st_next.port[pi].timed   = pwdata[`PRP_CTRL_TIMED];
                    st_next.port[pi].cond_en = pwdata[`PRP_CTRL_COND];
                    st_next.port[pi].strb_en = pwdata[`PRP_CTRL_STRB];
                    st_next.port[pi].clk_sel = pwdata[`PRP_CTRL_CS_HI:`PRP_CTRL_CS_LO];
                    if (pwdata[`PRP_CTRL_CS_HI:`PRP_CTRL_CS_LO] >= 3'(`PRP_NCB)) begin
                        st_next.port[pi].clk_sel = `PRP_CS_RESET;
                    end
                end
                `PRP_R_DATA: begin
                    if (st_reg.port[pi].dir_out) begin
                        st_next.port[pi].xfer      = pwdata;
                        st_next.port[pi].xfer_full = 1'b1;
                    end
                end
                `PRP_R_TIME: begin
                    // writing a time arms the delayed transfer
                    st_next.port[pi].time_at = pwdata[15:0];
                    st_next.port[pi].timed   = 1'b1;
                end
                `PRP_R_COND:  st_next.port[pi].cond = pwdata & 32'((64'h1 << PW[pi]) - 64'h1);
                default: begin
                end
            endcase
        end else if (wr && !st_reg.pslverr && paddr[8] && (ci != 3'h0)
                     && (ci < 3'(`PRP_NCB))) begin
            st_next.cb[ci].src_port = pwdata[`PRP_CB_SRC];
            st_next.cb[ci].div      = pwdata[`PRP_CB_DIV_HI:`PRP_CB_DIV_LO];
            st_next.cb[ci].divcnt   = '0;
        end
    end

    always_ff @(posedge clock or negedge rst_b) begin
        if (!rst_b) begin
            // all ports on block zero after reset
            st_reg <= '0;
        end else if (clk_en) begin
            st_reg <= st_next;
        end
    end

    assign pready  = clk_en;
    assign prdata  = st_reg.prdata;
    assign pslverr = st_reg.pslverr;

    always_comb begin
        for (int p = 0; p < `PRP_NPORT; p++) begin
            output_strobe[p] = st_reg.port[p].ostrobe;
            port_event[p]    = st_reg.port[p].evt;
        end
    end
endmodule
`default_nettype wire

//--- prp_top_assertions.sv
// checker for the port block register bus and pins
`timescale 1ns/1ps
`default_nettype none
module prp_top_assertions (
    input wire logic        clock,
    input wire logic        rst_b,
    input wire logic        clk_en,
    input wire logic        psel,
    input wire logic        penable,
    input wire logic        pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [31:0] prdata,
    input wire logic        pready,
    input wire logic        pslverr,
    input wire logic [31:0] pin_in,
    input wire logic [31:0] pin_out,
    input wire logic [31:0] pin_oe,
    input wire logic        link_enable,
    input wire logic [4:0]  input_strobe,
    input wire logic [4:0]  output_strobe,
    input wire logic [4:0]  port_event
);
    default clocking dc @(posedge clock);
    endclocking
    default disable iff (!rst_b);
    logic acc;
    logic mapped;
    assign acc = psel && penable && pready;
    assign mapped = (paddr[1:0] == 2'h0) && ((paddr < 12'h0A0 && paddr[4:0] <= 5'h18)
                    || (paddr >= 12'h100 && paddr <= 12'h114));
    property p_ready;
        pready == clk_en;
    endproperty
    a_ready: assert property (p_ready)
        else $error("pready differs from clk_en");
    property p_link;
        link_enable |-> pin_oe[31:24] == 8'h00;
    endproperty
    a_link: assert property (p_link)
        else $error("link pins still driven");
    property p_err;
        acc |-> pslverr == !mapped;
    endproperty
    a_err: assert property (p_err)
        else $error("pslverr wrong for address");
    property p_rd_hold;
        acc |=> $stable(prdata);
    endproperty
    a_rd_hold: assert property (p_rd_hold)
        else $error("prdata changed after access");
    property p_err_hold;
        acc |=> $stable(pslverr);
    endproperty
    a_err_hold: assert property (p_err_hold)
        else $error("pslverr changed after access");
    property p_rst;
        $rose(rst_b) |-> pin_oe == 32'h0 && output_strobe == 5'h0 && port_event == 5'h0;
    endproperty
    a_rst: assert property (p_rst)
        else $error("pins active after reset");
    property p_frz_pin;
        !clk_en ##1 $stable(link_enable) |-> $stable(pin_oe) && $stable(pin_out);
    endproperty
    a_frz_pin: assert property (p_frz_pin)
        else $error("pins moved without clock enable");
    property p_frz_flag;
        !clk_en |=> $stable(output_strobe) && $stable(port_event);
    endproperty
    a_frz_flag: assert property (p_frz_flag)
        else $error("strobe or event moved without clock enable");
endmodule
bind prp_top prp_top_assertions chk (.clock, .rst_b, .clk_en, .psel, .penable, .pwrite,
    .paddr, .pwdata, .prdata, .pready, .pslverr, .pin_in, .pin_out, .pin_oe,
    .link_enable, .input_strobe, .output_strobe, .port_event);
`default_nettype wire

//--- tb_top.sv
// self-checking bench for the port block over APB
`timescale 1ns/1ps
`default_nettype none
module tb_top;
    localparam logic [31:0] D = 32'hA5C3_0F96;
    logic        clock = 1'b0;
    logic        rst_b = 1'b0;
    logic        clk_en = 1'b1;
    logic        psel = 1'b0;
    logic        penable = 1'b0;
    logic        pwrite = 1'b0;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h0;
    logic        link_enable = 1'b0;
    logic [31:0] prdata;
    logic        pready;
    logic        pslverr;
    logic [31:0] pin_in;
    logic [31:0] pin_out;
    logic [31:0] pin_oe;
    logic [4:0]  input_strobe;
    logic [4:0]  output_strobe;
    logic [4:0]  port_event;
    logic [31:0] rd;
    logic        er;
    logic [15:0] c0;
    int          error_cnt = 0;
    int          checked = 0;
    always #20 clock = ~clock;
    prp_top dut (.clock, .rst_b, .clk_en, .psel, .penable, .pwrite, .paddr, .pwdata,
        .prdata, .pready, .pslverr, .pin_in, .pin_out, .pin_oe, .link_enable,
        .input_strobe, .output_strobe, .port_event);
    prp_ext_model ext (.clock, .pin_out, .pin_oe, .pin_in, .input_strobe);
    task automatic finish_test;
        $display("mismatches %0d comparisons %0d", error_cnt, checked);
        if (error_cnt == 0 && checked > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask
    task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
        checked++;
        if (g !== e) begin
            error_cnt++;
            $display("mismatch %s expected %h seen %h", n, e, g);
        end
    endtask
    function automatic logic [11:0] ad(input int p, input int r);
        return 12'(p * 32 + r * 4);
    endfunction
    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        int n;
        n = 0;
        @(posedge clock);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge clock);
        penable <= 1'b1;
        @(posedge clock);
        while (pready !== 1'b1) begin
            n++;
            if (n > 100) begin
                error_cnt++;
                finish_test();
            end
            @(posedge clock);
        end
        rd = prdata;
        er = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    task automatic wait_evt(input int p);
        int n;
        n = 0;
        @(negedge clock);
        while (port_event[p] !== 1'b1) begin
            n++;
            if (n > 200) begin
                error_cnt++;
                finish_test();
            end
            @(negedge clock);
        end
    endtask
    initial begin
        repeat (20000) @(posedge clock);
        error_cnt++;
        finish_test();
    end
    initial begin
        repeat (4) @(posedge clock);
        rst_b <= 1'b1;
        for (int p = 0; p < 5; p++) begin
            apb(1'b0, ad(p, 0), 32'h0);
            chk("ctrl", 32'h0, rd);
            chk("err", 32'h0, er);
        end
        apb(1'b0, 12'h01C, 32'h0);
        chk("unmapped", 32'h1, er);
        apb(1'b1, 12'h100, 32'h0000_0301);
        apb(1'b0, 12'h100, 32'h0);
        chk("cb0", 32'h0, rd);
        apb(1'b1, 12'h104, 32'h0000_0101);
        apb(1'b0, 12'h104, 32'h0);
        chk("cb1", 32'h0000_0101, rd);
        apb(1'b1, ad(3, 0), 32'h1);
        apb(1'b0, ad(3, 3), 32'h0);
        c0 = rd[15:0];
        apb(1'b0, ad(3, 3), 32'h0);
        chk("count", {16'h0, c0 + 16'h3}, rd);
        apb(1'b1, ad(3, 0), 32'h0000_0101);
        apb(1'b0, ad(3, 3), 32'h0);
        c0 = rd[15:0];
        ext.tick_src(4);
        apb(1'b0, ad(3, 3), 32'h0);
        chk("srccount", {16'h0, c0 + 16'h2}, rd);
        apb(1'b1, ad(3, 0), 32'h0);
        for (int m = 0; m < 2; m++) begin
            apb(1'b1, ad(0, 0), m ? 32'h27 : 32'h23);
            apb(1'b1, ad(0, 1), D);
            wait_evt(0);
            for (int i = 0; i < 32; i++) begin
                @(negedge clock);
                chk("oe", (m && D[i]) ? 32'h0 : 32'h1, pin_oe[0]);
                if (!m || !D[i]) chk("out", m ? 32'h0 : D[i], pin_out[0]);
                chk("ostrb", 32'h1, output_strobe[0]);
            end
        end
        apb(1'b1, ad(0, 0), 32'h2B);
        apb(1'b0, ad(0, 3), 32'h0);
        c0 = rd[15:0] + 16'h0028;
        apb(1'b1, ad(0, 2), {16'h0, c0});
        apb(1'b1, ad(0, 1), D);
        er = 1'b0;
        repeat (20) begin
            @(negedge clock);
            er = er | port_event[0];
        end
        chk("early", 32'h0, er);
        wait_evt(0);
        apb(1'b0, ad(0, 4), 32'h0);
        chk("stamp", {16'h0, c0}, rd);
        apb(1'b1, ad(0, 0), 32'h0);
        apb(1'b1, ad(2, 0), 32'h21);
        fork
            ext.send(D, 8, 2);
            wait_evt(2);
        join
        apb(1'b0, ad(2, 5), 32'h0);
        chk("full", 32'h1, rd[0]);
        apb(1'b0, ad(2, 1), 32'h0);
        chk("indata", D, rd);
        apb(1'b0, ad(2, 5), 32'h0);
        chk("empty", 32'h0, rd[0]);
        apb(1'b1, ad(2, 6), 32'h96);
        apb(1'b1, ad(2, 0), 32'h31);
        fork
            ext.send(32'h9696_9696, 8, 2);
            wait_evt(2);
        join
        apb(1'b0, ad(2, 1), 32'h0);
        chk("condin", 32'h9696_9696, rd);
        ext.send(D, 8, 2);
        apb(1'b0, ad(2, 5), 32'h0);
        chk("condblk", 32'h0, rd[0]);
        apb(1'b1, ad(2, 0), 32'h0);
        apb(1'b1, ad(4, 0), 32'h3);
        apb(1'b1, ad(1, 0), 32'h1);
        apb(1'b1, ad(4, 1), 32'hFFFF_FFFF);
        wait_evt(4);
        repeat (2) @(negedge clock);
        chk("share", 32'hFFFF_FFF0, pin_oe);
        @(posedge clock);
        link_enable <= 1'b1;
        @(negedge clock);
        chk("link", 32'h00FF_FFF0, pin_oe);
        apb(1'b0, ad(1, 3), 32'h0);
        c0 = rd[15:0];
        @(posedge clock);
        clk_en <= 1'b0;
        repeat (3) @(posedge clock);
        clk_en <= 1'b1;
        @(negedge clock);
        chk("frozen", 32'h00FF_FFF0, pin_oe);
        apb(1'b0, ad(1, 3), 32'h0);
        chk("frzcount", {16'h0, c0 + 16'h4}, rd);
        finish_test();
    end
endmodule
`default_nettype wire
